// ---- design/pclp_defs.svh ----
// Purpose: constants of the parallel configuration load port
// Assumes: 250 MHz system clock
// Notes: times kept in their own unit, cycle counts derived
`ifndef PCLP_DEFS_SVH
`define PCLP_DEFS_SVH
`define PCLP_CLK_MHZ 250
`define PCLP_POR_FAST_MS 4
`define PCLP_POR_STD_MS 100
`define PCLP_POR_FAST_CYC (`PCLP_POR_FAST_MS * 1000 * `PCLP_CLK_MHZ)
`define PCLP_POR_STD_CYC (`PCLP_POR_STD_MS * 1000 * `PCLP_CLK_MHZ)
`define PCLP_IMAGE_WORDS 1024
`define PCLP_INIT_EDGES 2
`define PCLP_MEM_AW 10
`define PCLP_CHK_INIT 16'hFFFF
`endif

// ---- design/pclp_pkg.sv ----
// Purpose: types of the parallel configuration load port
// Assumes: nothing
// Notes: one-hot state codes
package pclp_pkg;
  typedef enum logic [5:0] {
    PCLP_POR    = 6'h01,
    PCLP_IDLE   = 6'h02,
    PCLP_LOAD   = 6'h04,
    PCLP_INIT   = 6'h08,
    PCLP_USER   = 6'h10,
    PCLP_ERROR  = 6'h20
  } pclp_state_t;
endpackage

// ---- design/pclp_mem.sv ----
// Purpose: configuration image store, registered read
// Assumes: single clock
// Notes: one write port, one read port
`timescale 1ns/1ps
module pclp_mem #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // pclp_mem

// ---- design/pclp_port.sv ----
// Purpose: fast parallel load port of a programmable device
// Assumes: pins sampled by i_clk_sys; strobe clock much slower
// Notes: last image word is a checksum; image held for user logic
// Function
// R1: all lines high in user mode; reconfig request low restarts load
// R2: status held low for the whole power-on delay after power-up
// R3: power-on delay chosen by mode select pin: fast or standard
// R4: ready only after status released; host waits for it
// R5: load_complete low after power-up and during loading
// R6: load_complete high only after full image received without error
// R7: host sends whole image then two more strobe falling edges
// R8: strobe ignored after configuration; host never floats it
// R9: host drives bits 15..0 or 7..0 per width; bus then user pins
// R10: host may pause with strobe low; data valid before rising edge
// R11: one strobe per word without decompression or security; with i_width16 low the code takes two strobes per word
// R12: init-finished pin driven low once its option bit is loaded
// R13: host retries with reconfig pulse if load_complete stays low
`timescale 1ns/1ps
`include "pclp_defs.svh"
module pclp_port #(
  parameter int POR_FAST_CYC = `PCLP_POR_FAST_CYC,
  parameter int POR_STD_CYC = `PCLP_POR_STD_CYC,
  parameter int IMAGE_WORDS = `PCLP_IMAGE_WORDS
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_reconfig_request_n,
  input wire logic i_load_strobe_clock,
  input wire logic [15:0] i_data,
  input wire logic i_mode_select_pins,
  input wire logic i_width16,
  input wire logic i_status_n,
  output logic o_status_n_oe,
  output logic o_load_complete_oe,
  output logic o_init_done_oe,
  output logic o_user_mode,
  output logic [15:0] o_user_bus,
  output logic [15:0] o_image_word,
  output logic o_load_error,
  output pclp_pkg::pclp_state_t o_state
);
  import pclp_pkg::*;

  localparam int AW = `PCLP_MEM_AW;

  function automatic logic [15:0] chk_next(input logic [15:0] c,
                                           input logic [15:0] d);
    chk_next = {c[14:0], c[15]} ^ d;
  endfunction

  logic [1:0] rq_s, clk_s, mode_s, st_s, w16_s;
  logic rq, load_strobe_clock, load_strobe_clock_d, mode;
  logic [15:0] d_s1, d_s2;
  pclp_state_t state;
  logic [31:0] por_cnt;
  logic [31:0] word_cnt;
  logic byte_hi;
  logic [7:0] low_byte;
  logic [15:0] chk;
  logic [1:0] init_edges;
  logic init_opt;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic [AW-1:0] rd_ptr;

  // two-stage synchronisers for all pins
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rq_s <= 2'h3;
      clk_s <= 2'h0;
      mode_s <= 2'h0;
      st_s <= 2'h0;
      w16_s <= 2'h0;
      d_s1 <= 16'h0000;
      d_s2 <= 16'h0000;
      load_strobe_clock_d <= 1'b0;
    end
    else
    begin
      rq_s <= {rq_s[0], i_reconfig_request_n};
      clk_s <= {clk_s[0], i_load_strobe_clock};
      mode_s <= {mode_s[0], i_mode_select_pins};
      st_s <= {st_s[0], i_status_n};
      w16_s <= {w16_s[0], i_width16};
      d_s1 <= i_data;
      d_s2 <= d_s1;
      load_strobe_clock_d <= clk_s[1];
    end
  end
  assign rq = rq_s[1];
  assign load_strobe_clock = clk_s[1];
  assign mode = mode_s[1];

  wire rise = load_strobe_clock & ~load_strobe_clock_d;
  wire fall = ~load_strobe_clock & load_strobe_clock_d;
  wire last_word = (word_cnt == 32'(IMAGE_WORDS - 1));
  wire word_done = rise & (w16_s[1] | byte_hi);
  wire [15:0] word = w16_s[1] ? d_s2 : {d_s2[7:0], low_byte};

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= PCLP_POR;
      por_cnt <= 32'h0;
    end
    else
    begin
      case (state)
        PCLP_POR:
        begin
          por_cnt <= por_cnt + 32'h1;
          if (por_cnt >= 32'((mode ? POR_FAST_CYC : POR_STD_CYC) - 1)) // R3
          begin
            state <= PCLP_IDLE; // R2
          end
        end
        PCLP_IDLE:
        begin
          if (rq && st_s[1]) // R4
          begin
            state <= PCLP_LOAD;
          end
        end
        PCLP_LOAD:
        begin
          if (!rq)
          begin
            state <= PCLP_IDLE; // R1
          end
          else if (word_done && last_word)
          begin
            state <= (chk_next(chk, word) == 16'h0000) ? PCLP_INIT
                     : PCLP_ERROR; // R6
          end
        end
        PCLP_INIT:
        begin
          if (!rq)
          begin
            state <= PCLP_IDLE;
          end
          else if (fall && init_edges == 2'(`PCLP_INIT_EDGES - 1)) // R7
          begin
            state <= PCLP_USER;
          end
        end
        PCLP_USER, PCLP_ERROR:
        begin
          if (!rq)
          begin
            state <= PCLP_IDLE; // R1
          end
        end
        default:
        begin
          state <= PCLP_POR;
        end
      endcase
    end
  end

  // word assembly; strobe rising edges count only while loading
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      word_cnt <= 32'h0;
      byte_hi <= 1'b0;
      low_byte <= 8'h00;
      chk <= `PCLP_CHK_INIT;
      mem_we <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= 16'h0000;
    end
    else
    begin
      mem_we <= 1'b0;
      if (state != PCLP_LOAD)
      begin
        word_cnt <= 32'h0;
        byte_hi <= 1'b0;
        chk <= `PCLP_CHK_INIT;
      end
      else if (rise) // R11
      begin
        if (!w16_s[1] && !byte_hi) // R9
        begin
          low_byte <= d_s2[7:0];
          byte_hi <= 1'b1;
        end
        else
        begin
          byte_hi <= 1'b0;
          word_cnt <= word_cnt + 32'h1;
          chk <= chk_next(chk, word);
          mem_we <= 1'b1;
          mem_waddr <= word_cnt[AW-1:0];
          mem_wdata <= word;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      init_edges <= 2'h0;
      init_opt <= 1'b0;
    end
    else
    begin
      if (state != PCLP_INIT)
      begin
        init_edges <= 2'h0;
      end
      else if (fall)
      begin
        init_edges <= init_edges + 2'h1;
      end
      if (mem_we && mem_waddr == '0)
      begin
        init_opt <= mem_wdata[0]; // R12
      end
      else if (state == PCLP_IDLE)
      begin
        init_opt <= 1'b0;
      end
    end
  end

  // outputs; load_strobe_clock ignored in user mode
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_status_n_oe <= 1'b1;
      o_load_complete_oe <= 1'b1;
      o_init_done_oe <= 1'b0;
      o_user_mode <= 1'b0;
      o_user_bus <= 16'h0000;
      o_load_error <= 1'b0;
      o_state <= PCLP_POR;
      rd_ptr <= '0;
    end
    else
    begin
      o_status_n_oe <= (state == PCLP_POR) || (state == PCLP_ERROR)
                       || (state == PCLP_IDLE && !rq); // R2
      o_load_complete_oe <= !(state == PCLP_INIT || state == PCLP_USER); // R5
      o_init_done_oe <= init_opt && state != PCLP_USER; // R12
      o_user_mode <= (state == PCLP_USER); // R8
      o_user_bus <= (state == PCLP_USER) ? d_s2 : 16'h0000; // R9
      o_load_error <= (state == PCLP_ERROR);
      o_state <= state;
      rd_ptr <= rd_ptr + AW'(1);
    end
  end

  pclp_mem #(.AW(AW), .DW(16)) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(rd_ptr),
    .o_rdata(o_image_word)
  );

  sequence por_done_s;
    state == PCLP_POR ##1 state == PCLP_IDLE;
  endsequence

  por_status_low_a: assert property (@(posedge i_clk_sys) // R2
    disable iff (!i_reset_n) state == PCLP_POR |-> ##1 o_status_n_oe)
    else $error("status released during power-on delay");
  por_release_a: assert property (@(posedge i_clk_sys) // R4
    disable iff (!i_reset_n)
    por_done_s |-> por_cnt == 32'(mode ? POR_FAST_CYC : POR_STD_CYC))
    else $error("power-on delay skipped");
  done_low_load_a: assert property (@(posedge i_clk_sys) // R5
    disable iff (!i_reset_n) state == PCLP_LOAD |-> ##1 o_load_complete_oe)
    else $error("load_complete released while loading");
  done_good_a: assert property (@(posedge i_clk_sys) // R6
    disable iff (!i_reset_n)
    $rose(state == PCLP_INIT) |-> $past(state) == PCLP_LOAD
      && $past(last_word))
    else $error("load_complete without full image");
  user_two_edges_a: assert property (@(posedge i_clk_sys) // R7
    disable iff (!i_reset_n)
    $rose(state == PCLP_USER) |-> $past(fall) && $past(init_edges) == 2'h1)
    else $error("user mode without two falling edges");
  restart_req_a: assert property (@(posedge i_clk_sys) // R1
    disable iff (!i_reset_n)
    (state == PCLP_USER && !rq) |-> ##1 state == PCLP_IDLE)
    else $error("reconfig request ignored");
  user_ignores_a: assert property (@(posedge i_clk_sys) // R8
    disable iff (!i_reset_n)
    (state == PCLP_USER && rq) |-> ##1 state == PCLP_USER ##1 o_user_mode)
    else $error("strobe disturbed user mode");
  por_mode_a: assert property (@(posedge i_clk_sys) // R3
    disable iff (!i_reset_n)
    por_done_s |-> $past(por_cnt) + 32'h1 >=
      32'(mode ? POR_FAST_CYC : POR_STD_CYC) - 32'h1)
    else $error("power-on delay length wrong");
  init_pin_a: assert property (@(posedge i_clk_sys) // R12
    disable iff (!i_reset_n)
    (init_opt && state == PCLP_INIT) |-> ##1 o_init_done_oe)
    else $error("init-finished pin not driven low");
endmodule // pclp_port

// ---- verification/pclp_host.sv ----
// Purpose: host model driving the parallel load port pins
// Assumes: strobe period of 40 system clocks (160 ns)
// Notes: strobe rests low between words; bus is always driven
`timescale 1ns/1ps
module pclp_host (
  input wire logic i_clk_sys,
  input wire logic i_status_n,
  output logic o_reconfig_request_n,
  output logic o_load_strobe_clock,
  output logic [15:0] o_data
);
  initial
  begin
    o_reconfig_request_n = 1'b1;
    o_load_strobe_clock = 1'b0;
    o_data = 16'h0000;
  end
  // data settles in the low half, well before the rise
  task automatic strobe_cycle(input logic [15:0] d);
    @(posedge i_clk_sys);
    o_data <= d;
    repeat (19) @(posedge i_clk_sys);
    o_load_strobe_clock <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    o_load_strobe_clock <= 1'b0;
  endtask
  task automatic send_word(input logic [15:0] d, input logic w16);
    if (w16)
      strobe_cycle(d);
    else
    begin
      strobe_cycle({~d[7:0], d[7:0]});
      strobe_cycle({~d[15:8], d[15:8]});
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (i_status_n !== 1'b1 && n < 1000)
    begin
      @(posedge i_clk_sys);
      n++;
    end
  endtask
  task automatic init_edges();
    strobe_cycle(o_data);
    strobe_cycle(o_data);
  endtask
  task automatic reconfig_pulse();
    @(posedge i_clk_sys);
    o_reconfig_request_n <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    o_reconfig_request_n <= 1'b1;
  endtask
endmodule // pclp_host

// ---- verification/parallel_config_load_port_tb.sv ----
// Purpose: self-checking bench of the parallel load port
// Assumes: short power-on counts, four-word image
// Notes: status wire has a pull-up; host model drives the pins
`timescale 1ns/1ps
module parallel_config_load_port_tb;
  import pclp_pkg::*;
  localparam int FAST = 50;
  localparam int STD = 120;
  logic clk_sys = 1'b0;
  logic reset_n;
  logic mode_select;
  logic width16;
  logic reconfig_n;
  logic strobe;
  logic [15:0] data;
  logic status_n;
  logic status_oe, lc_oe, init_oe, user_mode, load_error;
  logic [15:0] user_bus, image_word;
  pclp_state_t state;
  int mismatches = 0;
  int check_count = 0;
  always #2 clk_sys = ~clk_sys;
  assign status_n = ~status_oe;
  pclp_port #(.POR_FAST_CYC(FAST), .POR_STD_CYC(STD), .IMAGE_WORDS(4))
    pclp_port_i (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
    .i_reconfig_request_n(reconfig_n), .i_load_strobe_clock(strobe),
    .i_data(data), .i_mode_select_pins(mode_select), .i_width16(width16),
    .i_status_n(status_n), .o_status_n_oe(status_oe),
    .o_load_complete_oe(lc_oe), .o_init_done_oe(init_oe),
    .o_user_mode(user_mode), .o_user_bus(user_bus),
    .o_image_word(image_word),
    .o_load_error(load_error), .o_state(state));
  pclp_host pclp_host_i (.i_clk_sys(clk_sys), .i_status_n(status_n),
    .o_reconfig_request_n(reconfig_n), .o_load_strobe_clock(strobe),
    .o_data(data));
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // last word that brings the running check to zero
  function automatic logic [15:0] seal(input logic [15:0] a, b, c);
    logic [15:0] s;
    s = 16'hFFFF ^ a;
    s = {s[14:0], s[15]} ^ b;
    s = {s[14:0], s[15]} ^ c;
    return {s[14:0], s[15]};
  endfunction
  task automatic por_test(input logic m, input int cyc);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    mode_select <= m;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (cyc - 4) @(posedge clk_sys);
    #1;
    check("status_oe held", status_oe, 1'b1);
    check("lc_oe power-up", lc_oe, 1'b1);
    repeat (10) @(posedge clk_sys);
    #1;
    check("status_oe released", status_oe, 1'b0);
  endtask
  task automatic load_good16();
    logic [15:0] img [4];
    logic found;
    img = '{16'h0001, 16'h1234, 16'hBEEF, 16'h0000};
    img[3] = seal(img[0], img[1], img[2]);
    pclp_host_i.wait_ready();
    for (int k = 0; k < 3; k++)
      pclp_host_i.send_word(img[k], 1'b1);
    #1;
    check("lc_oe loading", lc_oe, 1'b1);
    check("init_oe option", init_oe, 1'b1);
    pclp_host_i.send_word(img[3], 1'b1);
    #1;
    check("lc_oe done", lc_oe, 1'b0);
    pclp_host_i.init_edges();
    pclp_host_i.send_word(16'hA55A, 1'b1);
    repeat (4) @(posedge clk_sys);
    #1;
    check("user_mode", user_mode, 1'b1);
    check("init_oe user", init_oe, 1'b0);
    check("status_oe user", status_oe | lc_oe, 1'b0);
    check("user_bus", user_bus, 16'hA55A);
    check("state", state, PCLP_USER);
    // stored image is read back on a free-running address
    found = 1'b0;
    for (int n = 0; n < 1100 && !found; n++)
    begin
      @(posedge clk_sys);
      #1;
      if (image_word === img[0])
        found = 1'b1;
    end
    check("image_word first", found, 1'b1);
    for (int k = 1; k < 4; k++)
    begin
      @(posedge clk_sys);
      #1;
      check("image_word", image_word, img[k]);
    end
  endtask
  task automatic bad_then_retry();
    logic [15:0] img [4];
    img = '{16'h0100, 16'h00FF, 16'h8001, 16'h0000};
    img[3] = seal(img[0], img[1], img[2]) ^ 16'h0004;
    width16 <= 1'b0;
    pclp_host_i.reconfig_pulse();
    #1;
    check("user_mode restart", user_mode, 1'b0);
    check("lc_oe restart", lc_oe, 1'b1);
    for (int pass = 0; pass < 2; pass++)
    begin
      pclp_host_i.wait_ready();
      for (int k = 0; k < 4; k++)
        pclp_host_i.send_word(img[k], 1'b0);
      #1;
      check("lc_oe byte load", lc_oe, pass == 0);
      check("load_error", load_error, pass == 0);
      check("init_oe no option", init_oe, 1'b0);
      if (pass == 0)
        pclp_host_i.reconfig_pulse();
      img[3] = img[3] ^ 16'h0004;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
  initial
  begin
    reset_n = 1'b0;
    mode_select = 1'b1;
    width16 = 1'b1;
    por_test(1'b0, STD);
    por_test(1'b1, FAST);
    load_good16();
    bad_then_retry();
    end_sim();
  end
endmodule // parallel_config_load_port_tb
